// ==== evt_pkg.sv ====
// Constants, register map and carrier types shared by the event-input dispatch block
package evt_pkg;
    localparam int NUM_EVT = 6;
    localparam int SMALL_EVT = 4;
    localparam int CODE_W = 4;
    localparam int SP_W = 3;

    // Input stability time, kept in its own unit, and the derived cycle count
    localparam int CLK_HZ = 100_000_000;
    localparam int DEBOUNCE_MS = 50;
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
    localparam int DEB_CNT_W = 23;

    // Register byte offsets on the AHB-Lite slave
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_ASSIGN = 8'h04;
    localparam logic [7:0] OFS_DEADBAND = 8'h08;
    localparam logic [7:0] OFS_TUNE = 8'h0c;
    localparam logic [7:0] OFS_COOL_PB = 8'h10;
    localparam logic [7:0] OFS_COOL_IT = 8'h14;
    localparam logic [7:0] OFS_COOL_DT = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;

    // Reset and reload values
    localparam logic [15:0] DEADBAND_RST = 16'h0000;
    localparam logic [1:0] TUNE_METHOD_RST = 2'h0;
    localparam logic [15:0] COOL_PB_TEMP_DEF = 16'h0050;
    localparam logic [15:0] COOL_PB_ANALOG_DEF = 16'h0064;
    localparam logic [15:0] COOL_IT_DEF_1S = 16'h00e9;
    localparam logic [15:0] COOL_IT_DEF_01S = 16'h091a;
    localparam logic [15:0] COOL_DT_DEF_1S = 16'h0028;
    localparam logic [15:0] COOL_DT_DEF_01S = 16'h0190;

    typedef enum logic [3:0] {
        FN_NONE = 4'h0,
        FN_RUN_STOP = 4'h1,
        FN_AUTO_MANUAL = 4'h2,
        FN_PROGRAM_LAUNCH = 4'h3,
        FN_INVERT_DIR = 4'h4,
        FN_SP_SOURCE = 4'h5,
        FN_FULL_TUNE = 4'h6,
        FN_PARTIAL_TUNE = 4'h7,
        FN_SETTING_LOCK = 4'h8,
        FN_COMMS_WRITE = 4'h9,
        FN_ALARM_CLEAR = 4'ha,
        FN_SEL_BIT0 = 4'hb,
        FN_SEL_BIT1 = 4'hc,
        FN_SEL_BIT2 = 4'hd
    } evtFunc_t;

    // Configuration word, bit 11 down to bit 0
    typedef struct packed {
        logic largeVariant;
        logic hasRemoteSp;
        logic hasComms;
        logic workBitSrc;
        logic analogInput;
        logic progPatternOn;
        logic heatCool;
        logic twoStateControl;
        logic mspOff;
        logic [SP_W-1:0] keySel;
    } cfg_t;

    localparam logic [11:0] CFG_RST = 12'h000;

    // Decoded operating commands
    typedef struct packed {
        logic controlStopped;
        logic manualMode;
        logic programRun;
        logic invertDir;
        logic remoteSp;
        logic fullTune;
        logic partialTune;
        logic settingLock;
        logic commsWrite;
        logic alarmHoldClear;
    } ctrlOut_t;

    // Heating/cooling configuration seen by the control loop
    typedef struct packed {
        logic signed [15:0] deadBand;
        logic [1:0] tuneMethod;
        logic timeUnitTenth;
        logic [15:0] coolPb;
        logic [15:0] coolIt;
        logic [15:0] coolDt;
        logic threePosition;
        logic bumplessOk;
    } hcCfg_t;
endpackage

// ==== evt_debounce.sv ====
// One event-input channel: two-stage synchroniser followed by a stability filter
module evt_debounce #(
    parameter int DEBOUNCE_CYCLES = evt_pkg::DEBOUNCE_CYC
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic pinIn,
    output logic levelOut
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic stable;
        logic [evt_pkg::DEB_CNT_W-1:0] cnt;
    } debState_t;

    localparam logic [evt_pkg::DEB_CNT_W-1:0] LAST_CNT =
        evt_pkg::DEB_CNT_W'(DEBOUNCE_CYCLES - 1);

    debState_t state_r;
    debState_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        state_nxt.sync1 = pinIn;
        state_nxt.sync2 = state_r.sync1;
        if (state_r.sync2 == state_r.stable) begin
            state_nxt.cnt = '0;
        end else if (state_r.cnt >= LAST_CNT) begin
            // New level held for the full window: accept it
            state_nxt.stable = state_r.sync2;
            state_nxt.cnt = '0;
        end else begin
            state_nxt.cnt = state_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_r <= '0;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    assign levelOut = state_r.stable;
endmodule

// ==== sp_select.sv ====
// Active setpoint index from event-input selector bits or the key-set value
module sp_select (
    input wire logic [evt_pkg::NUM_EVT*evt_pkg::CODE_W-1:0] effAssign,
    input wire logic [evt_pkg::NUM_EVT-1:0] levels,
    input wire logic [evt_pkg::SP_W-1:0] keySel,
    input wire logic mspOff,
    output logic [evt_pkg::SP_W-1:0] spIndex,
    output logic selFromInputs
);
    logic [evt_pkg::SP_W-1:0] selBits;
    logic [evt_pkg::SP_W-1:0] selAssigned;

    always_comb begin
        selBits = '0;
        selAssigned = '0;
        for (int i = 0; i < evt_pkg::NUM_EVT; i++) begin
            for (int b = 0; b < evt_pkg::SP_W; b++) begin
                if (effAssign[i*evt_pkg::CODE_W +: evt_pkg::CODE_W] ==
                    evt_pkg::CODE_W'(evt_pkg::FN_SEL_BIT0 + b)) begin
                    selAssigned[b] = 1'b1;
                    selBits[b] = selBits[b] | levels[i];
                end
            end
        end
        selFromInputs = |selAssigned;
        if (selFromInputs) begin
            spIndex = selBits;
        end else if (!mspOff) begin
            spIndex = keySel;
        end else begin
            spIndex = '0;
        end
    end
endmodule

// ==== evt_dispatch.sv ====
// Event-input function dispatch with AHB-Lite register access
// Overview of operation
// - Eight setpoints exist; exactly one index 0..7 is active at all times.
// - Selector bits from inputs form the index, bit 0 least significant.
// - Selector bits with no assigned input count as zero.
// - Key-set value selects only when multi-setpoint is on and no selector bit assigned.
// - An input level is accepted only after staying stable for 50 ms.
// - Small variant has four inputs, large six, each with its own assignment.
// - Each assignment encodes one of fourteen functions including three selector bits.
// - Run/stop input on stops control, off runs; alarms keep following.
// - Stop indicator is active exactly while control is stopped.
// - Auto/manual input on gives manual control, off gives automatic.
// - Manual indicator lit in manual control, dark in automatic.
// - Program launch assignable with pattern off, but then has no effect.
// - Partial tuning assignable in heating/cooling, but inert there.
// - Setpoint source switch assignable only with remote setpoint hardware.
// - Comms write permit needs comms and is refused with work-bit source.
// - Dead band centred on setpoint; negative width means overlapping band.
// - Dead band resets to zero.
// - Cooling tuning method 0..3, reset 0, drives heating and cooling tuning.
// - Time-unit change reloads cooling band, integral 233 and derivative 40 for 1 s units, or 2330 and 400 for 0.1 s units.
// - Two-state control with heating/cooling gives three-position control.
// - Bumpless manual/auto switching not promised with an overlapping band.
//
// The implementer's own choices: the AHB-Lite slave port and the register addresses.
module evt_dispatch #(
    parameter int DEBOUNCE_CYCLES = evt_pkg::DEBOUNCE_CYC
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Event contacts
    input wire logic [evt_pkg::NUM_EVT-1:0] evtPin,
    // Decoded commands and indicators
    output evt_pkg::ctrlOut_t ctrl,
    output logic stopIndicator,
    output logic manualIndicator,
    output logic [evt_pkg::SP_W-1:0] activeSp,
    output evt_pkg::hcCfg_t hcCfg
);
    localparam int AW = evt_pkg::NUM_EVT * evt_pkg::CODE_W;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_WRITE = 2'b10
    } busState_t;

    typedef struct packed {
        busState_t busSt;
        logic [7:0] wAddr;
        logic [31:0] rdata;
        evt_pkg::cfg_t cfg;
        logic [AW-1:0] assignCodes;
        logic [15:0] deadBand;
        logic [1:0] tuneMethod;
        logic timeUnitTenth;
        logic [15:0] coolPb;
        logic [15:0] coolIt;
        logic [15:0] coolDt;
        evt_pkg::ctrlOut_t ctrl;
        logic [evt_pkg::SP_W-1:0] activeSp;
    } state_t;

    state_t state_r;
    state_t state_nxt;
    logic [evt_pkg::NUM_EVT-1:0] levels;
    logic [AW-1:0] effAssign;
    logic [evt_pkg::SP_W-1:0] spIndex;
    logic selFromInputs;
    logic addrPhase;

    // Whether a code may stand on a channel under the present configuration
    function automatic logic legalAssign(input logic [3:0] code, input int ch,
                                         input evt_pkg::cfg_t c);
        logic ok;
        ok = (code <= evt_pkg::FN_SEL_BIT2);
        if (ch >= evt_pkg::SMALL_EVT && !c.largeVariant) begin
            ok = 1'b0;
        end
        if (code == evt_pkg::FN_SP_SOURCE && !c.hasRemoteSp) begin
            ok = 1'b0;
        end
        if (code == evt_pkg::FN_COMMS_WRITE && (!c.hasComms || c.workBitSrc)) begin
            ok = 1'b0;
        end
        return ok;
    endfunction

    // True when any input carrying this function is on
    function automatic logic fnActive(input evt_pkg::evtFunc_t fn,
                                      input logic [AW-1:0] codes,
                                      input logic [evt_pkg::NUM_EVT-1:0] lv);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < evt_pkg::NUM_EVT; i++) begin
            if (codes[i*evt_pkg::CODE_W +: evt_pkg::CODE_W] == fn) begin
                hit = hit | lv[i];
            end
        end
        return hit;
    endfunction

    function automatic logic [15:0] defaultPb(input logic analog);
        return analog ? evt_pkg::COOL_PB_ANALOG_DEF : evt_pkg::COOL_PB_TEMP_DEF;
    endfunction

    genvar g;
    generate
        for (g = 0; g < evt_pkg::NUM_EVT; g++) begin : gen_evt
            evt_debounce #(
                .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
            ) u_deb (
                .clk_sys(clk_sys),
                .resetn(resetn),
                .ce(ce),
                .pinIn(evtPin[g]),
                .levelOut(levels[g])
            );
            // A code made illegal by a later configuration change acts as none
            assign effAssign[g*evt_pkg::CODE_W +: evt_pkg::CODE_W] =
                legalAssign(state_r.assignCodes[g*evt_pkg::CODE_W +: evt_pkg::CODE_W],
                            g, state_r.cfg)
                ? state_r.assignCodes[g*evt_pkg::CODE_W +: evt_pkg::CODE_W]
                : evt_pkg::FN_NONE;
        end
    endgenerate

    sp_select u_sp (
        .effAssign(effAssign),
        .levels(levels),
        .keySel(state_r.cfg.keySel),
        .mspOff(state_r.cfg.mspOff),
        .spIndex(spIndex),
        .selFromInputs(selFromInputs)
    );

    assign addrPhase = hsel && htrans[1] && hready;

    always_comb begin
        logic [3:0] code;
        code = '0;
        state_nxt = state_r;

        // Data phase of a write taken in the previous cycle
        if (state_r.busSt == BUS_WRITE) begin
            unique case (state_r.wAddr)
                evt_pkg::OFS_CFG: state_nxt.cfg = evt_pkg::cfg_t'(hwdata[11:0]);
                evt_pkg::OFS_ASSIGN: begin
                    for (int i = 0; i < evt_pkg::NUM_EVT; i++) begin
                        code = hwdata[i*evt_pkg::CODE_W +: evt_pkg::CODE_W];
                        // Refused codes leave the channel as it was
                        if (legalAssign(code, i, state_r.cfg)) begin
                            state_nxt.assignCodes[i*evt_pkg::CODE_W +: evt_pkg::CODE_W] =
                                code;
                        end
                    end
                end
                evt_pkg::OFS_DEADBAND: state_nxt.deadBand = hwdata[15:0];
                evt_pkg::OFS_TUNE: begin
                    state_nxt.tuneMethod = hwdata[1:0];
                    state_nxt.timeUnitTenth = hwdata[2];
                    if (hwdata[2] != state_r.timeUnitTenth) begin
                        state_nxt.coolPb = defaultPb(state_r.cfg.analogInput);
                        state_nxt.coolIt = hwdata[2] ? evt_pkg::COOL_IT_DEF_01S
                                                     : evt_pkg::COOL_IT_DEF_1S;
                        state_nxt.coolDt = hwdata[2] ? evt_pkg::COOL_DT_DEF_01S
                                                     : evt_pkg::COOL_DT_DEF_1S;
                    end
                end
                evt_pkg::OFS_COOL_PB: state_nxt.coolPb = hwdata[15:0];
                evt_pkg::OFS_COOL_IT: state_nxt.coolIt = hwdata[15:0];
                evt_pkg::OFS_COOL_DT: state_nxt.coolDt = hwdata[15:0];
                default: ;
            endcase
        end

        // Address phase: reads are sampled here so the data phase needs no wait
        state_nxt.busSt = BUS_IDLE;
        if (addrPhase) begin
            if (hwrite) begin
                state_nxt.busSt = BUS_WRITE;
                state_nxt.wAddr = haddr;
            end else begin
                unique case (haddr)
                    evt_pkg::OFS_CFG: state_nxt.rdata = {20'h00000, state_r.cfg};
                    evt_pkg::OFS_ASSIGN: state_nxt.rdata = {8'h00, state_r.assignCodes};
                    evt_pkg::OFS_DEADBAND: state_nxt.rdata = {16'h0000, state_r.deadBand};
                    evt_pkg::OFS_TUNE:
                        state_nxt.rdata = {29'h0000000, state_r.timeUnitTenth,
                                           state_r.tuneMethod};
                    evt_pkg::OFS_COOL_PB: state_nxt.rdata = {16'h0000, state_r.coolPb};
                    evt_pkg::OFS_COOL_IT: state_nxt.rdata = {16'h0000, state_r.coolIt};
                    evt_pkg::OFS_COOL_DT: state_nxt.rdata = {16'h0000, state_r.coolDt};
                    evt_pkg::OFS_STATUS:
                        state_nxt.rdata = {12'h000, selFromInputs, state_r.activeSp,
                                           state_r.ctrl, levels};
                    default: state_nxt.rdata = 32'h00000000;
                endcase
            end
        end

        // Command decode from the filtered contact levels
        state_nxt.ctrl.controlStopped =
            fnActive(evt_pkg::FN_RUN_STOP, effAssign, levels);
        state_nxt.ctrl.manualMode =
            fnActive(evt_pkg::FN_AUTO_MANUAL, effAssign, levels);
        state_nxt.ctrl.programRun = state_r.cfg.progPatternOn &&
            fnActive(evt_pkg::FN_PROGRAM_LAUNCH, effAssign, levels);
        state_nxt.ctrl.invertDir =
            fnActive(evt_pkg::FN_INVERT_DIR, effAssign, levels);
        state_nxt.ctrl.remoteSp =
            fnActive(evt_pkg::FN_SP_SOURCE, effAssign, levels);
        state_nxt.ctrl.fullTune =
            fnActive(evt_pkg::FN_FULL_TUNE, effAssign, levels);
        state_nxt.ctrl.partialTune = !state_r.cfg.heatCool &&
            fnActive(evt_pkg::FN_PARTIAL_TUNE, effAssign, levels);
        state_nxt.ctrl.settingLock =
            fnActive(evt_pkg::FN_SETTING_LOCK, effAssign, levels);
        state_nxt.ctrl.commsWrite =
            fnActive(evt_pkg::FN_COMMS_WRITE, effAssign, levels);
        state_nxt.ctrl.alarmHoldClear =
            fnActive(evt_pkg::FN_ALARM_CLEAR, effAssign, levels);
        state_nxt.activeSp = spIndex;
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_r.busSt <= BUS_IDLE;
            state_r.wAddr <= 8'h00;
            state_r.rdata <= 32'h00000000;
            state_r.cfg <= evt_pkg::CFG_RST;
            state_r.assignCodes <= '0;
            state_r.deadBand <= evt_pkg::DEADBAND_RST;
            state_r.tuneMethod <= evt_pkg::TUNE_METHOD_RST;
            state_r.timeUnitTenth <= 1'b0;
            state_r.coolPb <= evt_pkg::COOL_PB_TEMP_DEF;
            state_r.coolIt <= evt_pkg::COOL_IT_DEF_1S;
            state_r.coolDt <= evt_pkg::COOL_DT_DEF_1S;
            state_r.ctrl <= '0;
            state_r.activeSp <= '0;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    assign hrdata = state_r.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign ctrl = state_r.ctrl;
    // Alarm evaluation lives elsewhere and is not gated by the stop state
    assign stopIndicator = state_r.ctrl.controlStopped;
    assign manualIndicator = state_r.ctrl.manualMode;
    assign activeSp = state_r.activeSp;

    always_comb begin
        hcCfg.deadBand = state_r.deadBand;
        hcCfg.tuneMethod = state_r.tuneMethod;
        hcCfg.timeUnitTenth = state_r.timeUnitTenth;
        hcCfg.coolPb = state_r.coolPb;
        hcCfg.coolIt = state_r.coolIt;
        hcCfg.coolDt = state_r.coolDt;
        hcCfg.threePosition = state_r.cfg.twoStateControl && state_r.cfg.heatCool;
        // An overlapping band can make manual/auto switching bump
        hcCfg.bumplessOk = !(state_r.cfg.heatCool && state_r.deadBand[15]);
    end
endmodule

// ==== evt_contacts.sv ====
// Model of the external switch contacts wired to the event inputs
module evt_contacts (
    input wire logic clk_sys,
    output logic [evt_pkg::NUM_EVT-1:0] evtPin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial evtPin = '0;
    // Contacts move just after an edge and then stay put for cyc cycles.
    // A short cyc makes a bounce that the filter must reject.
    task automatic press(input logic [evt_pkg::NUM_EVT-1:0] lv, input int cyc);
        @(posedge clk_sys);
        evtPin <= lv;
        repeat (cyc) @(posedge clk_sys);
    endtask
endmodule

// ==== evt_dispatch_checker.sv ====
// Port-level assertions for the event-input dispatch block
module evt_dispatch_checker #(
    parameter int DEBOUNCE_CYCLES = 8
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic [evt_pkg::NUM_EVT-1:0] evtPin,
    input wire evt_pkg::ctrlOut_t ctrl,
    input wire logic stopIndicator,
    input wire logic manualIndicator,
    input wire logic [evt_pkg::SP_W-1:0] activeSp,
    input wire evt_pkg::hcCfg_t hcCfg
);
    timeunit 1ns;
    timeprecision 1ps;
    int pinAge_r;
    int busAge_r;
    logic [evt_pkg::NUM_EVT-1:0] pinPrev_r;
    // Ages of the last contact change and last bus write; config writes may move outputs
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pinAge_r <= 0;
            busAge_r <= 0;
        end else begin
            pinAge_r <= (evtPin != pinPrev_r) ? 0 : pinAge_r + 1;
            busAge_r <= (hsel && htrans[1] && hready && hwrite && ce) ? 0 : busAge_r + 1;
        end
        pinPrev_r <= evtPin;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    stop_ind_a: assert property (stopIndicator == ctrl.controlStopped)
        else $error("stop indicator differs from stop command");
    manual_ind_a: assert property (manualIndicator == ctrl.manualMode)
        else $error("manual indicator differs from manual command");
    rst_vals_a: assert property ($rose(resetn) |-> hcCfg.deadBand == 16'h0000
        && hcCfg.tuneMethod == 2'h0 && hcCfg.coolIt == 16'h00e9 && hcCfg.coolDt == 16'h0028)
        else $error("heating/cooling settings wrong after reset");
    cmd_settle_a: assert property ($changed(ctrl) && busAge_r > 4
        |-> pinAge_r >= DEBOUNCE_CYCLES)
        else $error("command moved before contacts were stable");
    sp_settle_a: assert property ($changed(activeSp) && busAge_r > 4
        |-> pinAge_r >= DEBOUNCE_CYCLES)
        else $error("setpoint index moved without a cause");
    bumpless_a: assert property (!hcCfg.bumplessOk |-> hcCfg.deadBand[15])
        else $error("bumpless dropped without an overlapping band");
    unit_reload_a: assert property ($changed(hcCfg.timeUnitTenth) |-> ##[0:1]
        hcCfg.coolIt == (hcCfg.timeUnitTenth ? 16'h091a : 16'h00e9))
        else $error("cooling integral not reloaded on unit change");
    rdata_hold_a: assert property (!(hsel && htrans[1] && hready && !hwrite && ce)
        |=> $stable(hrdata))
        else $error("read data moved without a read");
endmodule

// ==== evt_dispatch_tb_top.sv ====
// Self-checking bench for the event-input dispatch block
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
    $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module evt_dispatch_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DEB = 8;
    localparam int SETTLE = DEB + 8;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [5:0] evtPin;
    evt_pkg::ctrlOut_t ctrl;
    logic stopIndicator;
    logic manualIndicator;
    logic [2:0] activeSp;
    evt_pkg::hcCfg_t hcCfg;
    int bad_count = 0;
    int cmp_count = 0;
    logic [31:0] rnd = 32'hacca;
    logic [31:0] q;
    // Gated cases: config, code, channel, refused at write
    logic [11:0] gCfg [5] = '{12'h800, 12'h820, 12'h800, 12'hb00, 12'h000};
    int gCode [5] = '{3, 7, 5, 9, 1};
    int gCh [5] = '{1, 2, 3, 0, 4};
    logic gRef [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    logic [31:0] rstVal [9] = '{0, 0, 0, 0, 32'h50, 32'he9, 32'h28, 0, 0};
    always #5 clk_sys = ~clk_sys;
    evt_dispatch #(.DEBOUNCE_CYCLES(DEB)) u_evt_dispatch (
        .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .evtPin(evtPin), .ctrl(ctrl),
        .stopIndicator(stopIndicator), .manualIndicator(manualIndicator),
        .activeSp(activeSp), .hcCfg(hcCfg));
    evt_contacts u_evt_contacts (.clk_sys(clk_sys), .evtPin(evtPin));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic evt_pkg::ctrlOut_t cmdFor(input int code);
        return evt_pkg::ctrlOut_t'(10'h1 << (10 - code));
    endfunction
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic waitReady();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            bad_count++;
            end_of_test();
        end
    endtask
    // One single-word transfer; read data lands in q
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        waitReady();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitReady();
        q = hrdata;
    endtask
    task automatic settle();
        repeat (3) @(posedge clk_sys);
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys);
        bad_count++;
        end_of_test();
    end
    initial begin
        int i;
        int ch;
        logic [5:0] lv;
        logic [31:0] sel;
        logic [15:0] db;
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        ahb(1'b1, 8'h20, 32'hffffffff);
        for (i = 0; i < 9; i++) begin
            ahb(1'b0, 8'(4 * i), 32'h0);
            `CHK("reset value", rstVal[i], q)
        end
        $display("test reset values done");
        for (i = 0; i < 4; i++) begin
            ahb(1'b1, evt_pkg::OFS_TUNE, 32'(i));
            settle();
            `CHK("tune method", 2'(i), hcCfg.tuneMethod)
        end
        ahb(1'b1, evt_pkg::OFS_COOL_PB, 32'h64);
        ahb(1'b1, evt_pkg::OFS_COOL_IT, 32'h64);
        ahb(1'b1, evt_pkg::OFS_TUNE, 32'h4);
        ahb(1'b0, evt_pkg::OFS_COOL_IT, 32'h0);
        `CHK("integral reload", 32'h091a, q)
        ahb(1'b0, evt_pkg::OFS_COOL_DT, 32'h0);
        `CHK("derivative reload", 32'h0190, q)
        `CHK("band reload", 16'h0050, hcCfg.coolPb)
        ahb(1'b1, evt_pkg::OFS_TUNE, 32'h0);
        $display("test tuning done");
        ahb(1'b1, evt_pkg::OFS_CFG, 32'h030);
        for (i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            db = (i == 0) ? 16'hffff : rnd[15:0];
            ahb(1'b1, evt_pkg::OFS_DEADBAND, 32'(db));
            settle();
            `CHK("dead band", db, hcCfg.deadBand)
            `CHK("bumpless", ~db[15], hcCfg.bumplessOk)
            `CHK("three position", 1'b1, hcCfg.threePosition)
        end
        ahb(1'b1, evt_pkg::OFS_CFG, 32'h0);
        settle();
        `CHK("three position off", 1'b0, hcCfg.threePosition)
        $display("test heating cooling done");
        ahb(1'b1, evt_pkg::OFS_CFG, 32'he40);
        for (i = 1; i <= 10; i++) begin
            rnd = lfsr(rnd);
            ch = int'(rnd[7:0]) % 6;
            ahb(1'b1, evt_pkg::OFS_ASSIGN, 32'(i) << (4 * ch));
            u_evt_contacts.press(6'(1 << ch), SETTLE);
            `CHK("command on", cmdFor(i), ctrl)
            `CHK("stop lamp", (i == 1), stopIndicator)
            `CHK("manual lamp", (i == 2), manualIndicator)
            u_evt_contacts.press(6'h00, SETTLE);
            `CHK("command off", 10'h0, ctrl)
        end
        $display("test functions done");
        for (i = 0; i < 5; i++) begin
            ahb(1'b1, evt_pkg::OFS_ASSIGN, 32'h0);
            ahb(1'b1, evt_pkg::OFS_CFG, 32'(gCfg[i]));
            ahb(1'b1, evt_pkg::OFS_ASSIGN, 32'(gCode[i]) << (4 * gCh[i]));
            ahb(1'b0, evt_pkg::OFS_ASSIGN, 32'h0);
            if (gRef[i]) `CHK("refused code", 32'h0, q)
            u_evt_contacts.press(6'h3f, SETTLE);
            `CHK("gated command", 10'h0, ctrl)
            u_evt_contacts.press(6'h00, SETTLE);
        end
        $display("test gating done");
        for (i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            lv = (i == 0) ? 6'h3f : rnd[5:0];
            sel = (i < 4) ? 32'h0dcb : 32'hd000;
            u_evt_contacts.press(lv, SETTLE);
            ahb(1'b1, evt_pkg::OFS_CFG, {20'h0, 9'h100, rnd[8:6]});
            ahb(1'b1, evt_pkg::OFS_ASSIGN, sel);
            ahb(1'b0, evt_pkg::OFS_STATUS, 32'h0);
            settle();
            `CHK("levels", lv, q[5:0])
            `CHK("selector", (i < 4) ? lv[2:0] : {lv[3], 2'b00}, activeSp)
        end
        u_evt_contacts.press(6'h00, SETTLE);
        ahb(1'b1, evt_pkg::OFS_ASSIGN, 32'h0);
        for (i = 0; i < 9; i++) begin
            ahb(1'b1, evt_pkg::OFS_CFG, (i < 8) ? 32'h800 | 32'(i) : 32'h80f);
            settle();
            `CHK("key select", (i < 8) ? 3'(i) : 3'h0, activeSp)
        end
        $display("test setpoints done");
        ahb(1'b1, evt_pkg::OFS_ASSIGN, 32'h100000);
        u_evt_contacts.press(6'h20, 3);
        u_evt_contacts.press(6'h00, SETTLE);
        `CHK("bounce ignored", 10'h0, ctrl)
        u_evt_contacts.press(6'h20, DEB - 1);
        `CHK("not yet accepted", 1'b0, stopIndicator)
        repeat (SETTLE) @(posedge clk_sys);
        `CHK("stable accepted", 1'b1, stopIndicator)
        ce <= 1'b0;
        u_evt_contacts.press(6'h00, SETTLE);
        `CHK("frozen by enable", 1'b1, stopIndicator)
        ce <= 1'b1;
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        `CHK("reset command", 10'h0, ctrl)
        resetn <= 1'b1;
        $display("test filter done");
        end_of_test();
    end
endmodule
bind evt_dispatch evt_dispatch_checker #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES))
    u_evt_dispatch_checker (
    .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .evtPin(evtPin), .ctrl(ctrl),
    .stopIndicator(stopIndicator), .manualIndicator(manualIndicator),
    .activeSp(activeSp), .hcCfg(hcCfg));
